/* File: dv/ghm_chk_monitor.sv */
// Checker of the health monitor's output relations
`default_nettype none
module ghm_chk
    import ghm_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire ghm_analog_t           analog,
    input  wire logic                  loops_locked,
    input  wire ghm_cmd_t              cmd,
    input  wire logic [RATE_WIDTH-1:0] rate_raw,
    input  wire logic [TEMP_WIDTH-1:0] temp_raw,
    input  wire logic                  pass_out,
    input  wire logic                  adc_enable,
    input  wire logic [7:0]            status_byte,
    input  wire logic [RATE_WIDTH-1:0] rate_word,
    input  wire logic [TEMP_WIDTH-1:0] temp_word,
    input  wire logic                  temp_in_band
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Range saturation is left out on purpose: it must never fail the line
    wire logic fault = analog.over_drive | analog.under_drive | analog.demod_sat | analog.quad_excess;
    sequence s_fault_held; fault [*3]; endsequence
    sequence s_unlocked_held; !loops_locked [*3]; endsequence
    sequence s_self_held; status_byte[ST_SELF_BIT] [*3]; endsequence
    sequence s_analog_held; !adc_enable [*2]; endsequence
    property p_fault; s_fault_held |-> !pass_out; endproperty
    property p_unlock; s_unlocked_held |-> !pass_out; endproperty
    property p_self_fail; s_self_held |-> !pass_out; endproperty
    property p_offset; s_self_held |-> rate_word == $past(rate_raw) + SELF_TEST_OFFSET; endproperty
    property p_stat_fail; status_byte[ST_SELF_BIT] |-> status_byte[ST_FAIL_BIT]; endproperty
    property p_badsum; cmd.valid && !cmd.sum_ok && adc_enable |-> ##[1:2] status_byte[ST_BADSUM_BIT]; endproperty
    property p_temp_off; s_analog_held |-> temp_word == '0; endproperty
    property p_band;
        !$past(rst) |-> temp_in_band == ($past(temp_raw) >= TEMP_CODE_25C - TEMP_CODE_TOL
                                         && $past(temp_raw) <= TEMP_CODE_25C + TEMP_CODE_TOL);
    endproperty
    property p_reset; disable iff (1'b0) rst |=> status_byte == 8'h00 && !pass_out; endproperty
    property p_boot; $fell(rst) |-> !pass_out [*8]; endproperty
    a_fault: assert property (p_fault) else $error("pass high with failing check");
    a_unlock: assert property (p_unlock) else $error("pass high while unlocked");
    a_self_fail: assert property (p_self_fail) else $error("pass high in self-test");
    a_offset: assert property (p_offset) else $error("self-test offset wrong");
    a_stat_fail: assert property (p_stat_fail) else $error("fail bit clear in self-test");
    a_badsum: assert property (p_badsum) else $error("bad sum flag missing");
    a_temp_off: assert property (p_temp_off) else $error("temperature out in analogue mode");
    a_band: assert property (p_band) else $error("temperature band wrong");
    a_reset: assert property (p_reset) else $error("outputs not cleared in reset");
    a_boot: assert property (p_boot) else $error("pass rose before power-up checks");
endmodule
bind ghm_monitor ghm_chk u_chk (.mclk, .rst, .analog, .loops_locked, .cmd, .rate_raw, .temp_raw, .pass_out,
    .adc_enable, .status_byte, .rate_word, .temp_word, .temp_in_band);
`default_nettype wire

/* File: dv/ghm_host.sv */
// Host-side model that sends decoded command messages
`default_nettype none
module ghm_host
    import ghm_pkg::*;
(
    input  wire logic mclk,
    output var ghm_cmd_t cmd
);
    initial cmd = '0;
    // One message per call; the strobe drops at the next edge so calls never collide
    task automatic send(input logic sum_ok, input logic self_test);
        @(posedge mclk);
        cmd <= '{valid: 1'b1, sum_ok: sum_ok, self_test: self_test};
        @(posedge mclk);
        cmd <= '0;
    endtask
endmodule
`default_nettype wire

/* File: dv/ghm_monitor_tb.sv */
// Self-checking bench of the gyro health monitor
`default_nettype none
module ghm_monitor_tb
    import ghm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  mclk = 0, rst = 1, mode_digital_pin = 1, self_test_pin = 0, loops_locked = 1;
    logic                  cal_parity, reg_wr = 0, reg_rd = 0, bad_par = 0, bad_trim = 0;
    logic                  pass_out, adc_enable, temp_in_band, irq;
    logic [3:0]            cal_addr;
    logic [CAL_WIDTH-1:0]  cal_data, trim_readback;
    ghm_analog_t           analog = '0;
    ghm_cmd_t              cmd;
    logic [RATE_WIDTH-1:0] rate_raw = 16'h0100, rate_word;
    logic [TEMP_WIDTH-1:0] temp_raw = 10'h258, temp_word;
    logic [7:0]            status_byte, reg_rdata, reg_wdata = 8'h00;
    logic [1:0]            reg_addr = 2'h0;
    int                    err_count = 0, cmp_count = 0;
    // Calibration store with one-bit fault injection
    assign cal_data = {12'hA50, cal_addr};
    assign cal_parity = ^cal_data ^ bad_par;
    assign trim_readback = cal_data ^ {15'h0000, bad_trim};
    always #5 mclk = ~mclk;
    ghm_host host (.mclk, .cmd);
    ghm_monitor #(.SETTLE_CNT(20)) uut (.mclk, .rst, .mode_digital_pin, .self_test_pin, .cal_addr, .cal_data,
        .cal_parity, .trim_readback, .analog, .loops_locked, .cmd, .rate_raw, .temp_raw, .pass_out, .adc_enable,
        .status_byte, .rate_word, .temp_word, .temp_in_band, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq);
    task complete_run;
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task look(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wait_pass;
        int i;
        for (i = 0; i < 200 && pass_out !== 1'b1; i++) @(posedge mclk);
        #1;
        chk("pass_out", pass_out, 1);
        if (i == 200) complete_run;
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge mclk);
        reg_wr <= 0;
    endtask
    task rdc(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge mclk);
        reg_rd <= 0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    // ****************
    // Stimulus
    // ****************
    initial
    begin
        #200000 err_count++;
        complete_run;
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        look(30);
        chk("pass_out", pass_out, 0);
        wait_pass;
        chk("adc_enable", adc_enable, 1);
        chk("temp_word", temp_word, 16'h0258);
        chk("temp_in_band", temp_in_band, 1);
        @(posedge mclk) temp_raw <= 10'h243;
        look(2);
        chk("temp_in_band", temp_in_band, 0);
        for (int b = 1; b < 5; b++)
        begin
            @(posedge mclk) analog <= ghm_analog_t'(5'h01 << b);
            look(3);
            chk("pass_out", pass_out, 0);
            @(posedge mclk) analog <= '0;
            wait_pass;
        end
        @(posedge mclk) analog <= ghm_analog_t'(5'h01);
        look(4);
        chk("pass_out", pass_out, 1);
        analog <= '0;
        loops_locked <= 0;
        look(3);
        chk("pass_out", pass_out, 0);
        loops_locked <= 1;
        wait_pass;
        host.send(1, 1);
        look(2);
        chk("pass_out", pass_out, 0);
        chk("status_byte", status_byte, 8'h88);
        chk("rate_word", rate_word, 16'h0100 + SELF_TEST_OFFSET);
        host.send(0, 0);
        look(2);
        chk("status_byte", status_byte, 8'h98);
        host.send(1, 0);
        wait_pass;
        host.send(0, 1);
        look(2);
        chk("pass_out", pass_out, 1);
        chk("status_byte", status_byte, 8'h10);
        rdc(0, 8'h07);
        wr(0, 8'h07);
        rdc(0, 8'h00);
        rdc(2, 8'h10);
        rdc(3, 8'h00);
        wr(1, 8'h02);
        host.send(1, 0);
        host.send(0, 0);
        look(2);
        chk("irq", irq, 1);
        wr(1, 8'h00);
        look(1);
        chk("irq", irq, 0);
        rdc(1, 8'h00);
        @(posedge mclk) mode_digital_pin <= 0;
        look(6);
        chk("adc_enable", adc_enable, 0);
        chk("temp_word", temp_word, 0);
        host.send(1, 1);
        look(2);
        chk("status_byte", status_byte[3], 0);
        self_test_pin <= 1;
        look(6);
        chk("pass_out", pass_out, 0);
        self_test_pin <= 0;
        mode_digital_pin <= 1;
        wait_pass;
        @(posedge mclk) rst <= 1;
        host.send(1, 1);
        look(1);
        chk("status_byte", status_byte, 8'h00);
        bad_par <= 1;
        rst <= 0;
        look(80);
        chk("pass_out", pass_out, 0);
        @(posedge mclk) rst <= 1;
        bad_par <= 0;
        bad_trim <= 1;
        look(3);
        rst <= 0;
        look(80);
        chk("pass_out", pass_out, 0);
        @(posedge mclk) rst <= 1;
        bad_trim <= 0;
        look(3);
        rst <= 0;
        wait_pass;
        complete_run;
    end
endmodule
`default_nettype wire

/* File: pkg/ghm_pkg.sv */
// Package of constants and types for the gyro health monitor
`default_nettype none
package ghm_pkg;
    // Calibration store geometry
    localparam int CAL_WORDS      = 16;
    localparam int CAL_WIDTH      = 16;
    // Rate and temperature encodings
    localparam int RATE_WIDTH     = 16;
    localparam int TEMP_WIDTH     = 10;
    localparam logic [RATE_WIDTH-1:0] SELF_TEST_OFFSET = 16'h12C0;
    localparam logic [TEMP_WIDTH-1:0] TEMP_CODE_25C    = 10'h258;
    localparam logic [TEMP_WIDTH-1:0] TEMP_CODE_TOL    = 10'h014;
    localparam int TEMP_LSB_PER_C_X100 = 275;
    // Settling time of the resonance loops
    localparam int SETTLE_TIME_US = 100;
    localparam int CLK_MHZ        = 100;
    localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_MHZ;
    // Serial status byte fields
    localparam int ST_FAIL_BIT    = 7;
    localparam int ST_BADSUM_BIT  = 4;
    localparam int ST_SELF_BIT    = 3;
    // Interrupt status bit positions
    localparam int EV_FAIL        = 0;
    localparam int EV_BADSUM      = 1;
    localparam int EV_SELF        = 2;
    localparam int EV_N           = 3;

    typedef struct packed {
        logic over_drive;
        logic under_drive;
        logic demod_sat;
        logic quad_excess;
        logic range_sat;
    } ghm_analog_t;

    typedef struct packed {
        logic       valid;
        logic       sum_ok;
        logic       self_test;
    } ghm_cmd_t;
endpackage
`default_nettype wire

/* File: rtl/ghm_monitor.sv */
// Health monitor: power-up checks, loop monitors, self-test, temperature and status byte
`default_nettype none
// Behaviour
// - Pass/fail output is high only while every monitored check passes.
// - Power-up parity check of calibration store; any bad word fails.
// - Power-up verification of each trim conversion stage; mismatch fails.
// - Gain loop drive above upper limit fails.
// - Gain loop level below lower limit fails.
// - Fail held during start-up until resonance loops settle.
// - Rate demodulator saturation fails.
// - Exceeding selected output range alone does not fail.
// - Excess quadrature magnitude fails.
// - Bad serial checksum sets separate status flag, not the pass/fail line.
// - Self-test adds a fixed offset to the rate output.
// - Self-test active holds pass/fail at failing level.
// - Temperature code is readable only through the serial temperature word, in digital mode.
// - Temperature code 600 at 25 C, 2.75 codes per degree.
// - Mode select high enables converter and serial functions.
// - Commands ignored while reset is held.
// - Status failure bit set when self-test enabled or health fails.
module ghm_monitor
    import ghm_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
)(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Pins from outside
    input  wire logic                  mode_digital_pin,
    input  wire logic                  self_test_pin,
    // Calibration store read port
    output logic [$clog2(CAL_WORDS)-1:0] cal_addr,
    input  wire logic [CAL_WIDTH-1:0]  cal_data,
    input  wire logic                  cal_parity,
    // Trim conversion readback
    input  wire logic [CAL_WIDTH-1:0]  trim_readback,
    // Analogue comparators
    input  wire ghm_analog_t           analog,
    input  wire logic                  loops_locked,
    // Decoded serial command
    input  wire ghm_cmd_t              cmd,
    // Raw rate and temperature samples
    input  wire logic [RATE_WIDTH-1:0] rate_raw,
    input  wire logic [TEMP_WIDTH-1:0] temp_raw,
    // Outputs
    output logic                       pass_out,
    output logic                       adc_enable,
    output logic [7:0]                 status_byte,
    output logic [RATE_WIDTH-1:0]      rate_word,
    output logic [TEMP_WIDTH-1:0]      temp_word,
    output logic                       temp_in_band,
    // Interrupt register port
    input  wire logic [1:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    output logic                       irq
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] mode_sync;
    logic [2:0] self_sync;
    logic       mode_digital;
    logic       self_pin_q;

    always_ff @(posedge mclk)
    begin
        mode_sync <= {mode_sync[1:0], mode_digital_pin};
        self_sync <= {self_sync[1:0], self_test_pin};
    end

    // A change is accepted only once stages two and three agree
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_digital <= 1'b0;
            self_pin_q   <= 1'b0;
        end
        else
        begin
            if (mode_sync[1] == mode_sync[2])
                mode_digital <= mode_sync[2];
            if (self_sync[1] == self_sync[2])
                self_pin_q <= self_sync[2];
        end
    end

    assign adc_enable = mode_digital;

    // ****************************************
    // Power-up sequencer
    // ****************************************
    typedef enum logic [2:0] {ST_LOAD, ST_TRIM, ST_SETTLE, ST_RUN} ghm_state_t;
    ghm_state_t state;
    ghm_state_t next_state;

    // Sized from the module parameter so a longer settle time never truncates
    localparam int CNT_W = $clog2(SETTLE_CNT + 1) + 1;
    logic [$clog2(CAL_WORDS)-1:0] idx;
    logic [CNT_W-1:0]             settle_cnt;
    logic                         parity_bad;
    logic                         trim_bad;

    wire last_word   = (idx == ($clog2(CAL_WORDS))'(CAL_WORDS - 1));
    wire word_par_ok = (^cal_data) == cal_parity;
    wire trim_ok     = trim_readback == cal_data;
    wire settled     = loops_locked && (settle_cnt >= CNT_W'(SETTLE_CNT));

    assign cal_addr = idx;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_LOAD:   if (last_word) next_state = ST_TRIM;
            ST_TRIM:   if (last_word) next_state = ST_SETTLE;
            ST_SETTLE: if (settled) next_state = ST_RUN;
            // Losing lock means the loops are no longer at their set values
            ST_RUN:    if (!loops_locked) next_state = ST_SETTLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state      <= ST_LOAD;
            idx        <= '0;
            parity_bad <= 1'b0;
            trim_bad   <= 1'b0;
            settle_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_LOAD || state == ST_TRIM)
                idx <= idx + 1'b1;
            if (state == ST_LOAD && !word_par_ok)
                parity_bad <= 1'b1;
            if (state == ST_TRIM && !trim_ok)
                trim_bad <= 1'b1;
            // Restart settling whenever the loops lose lock
            if (state == ST_SETTLE)
                settle_cnt <= loops_locked ? settle_cnt + 1'b1 : '0;
            else
                settle_cnt <= '0;
        end
    end

    // ****************************************
    // Health combination
    // ****************************************
    logic self_cmd;
    logic self_active;
    logic health_fail;
    logic bad_sum;

    // Range saturation is deliberately not a failure term
    assign health_fail = parity_bad || trim_bad || (state != ST_RUN)
                       || analog.over_drive
                       || analog.under_drive
                       || analog.demod_sat
                       || analog.quad_excess;
    assign self_active = mode_digital ? self_cmd : self_pin_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
            pass_out <= 1'b0;
        else
            pass_out <= !(health_fail || self_active);
    end

    // ****************************************
    // Serial command intake
    // ****************************************
    // Reset is synchronous, so commands present while held are dropped
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            self_cmd <= 1'b0;
            bad_sum  <= 1'b0;
        end
        else if (cmd.valid && mode_digital)
        begin
            bad_sum <= !cmd.sum_ok;
            if (cmd.sum_ok)
                self_cmd <= cmd.self_test;
        end
    end

    // ****************************************
    // Data path
    // ****************************************
    wire [TEMP_WIDTH-1:0] temp_lo = TEMP_CODE_25C - TEMP_CODE_TOL;
    wire [TEMP_WIDTH-1:0] temp_hi = TEMP_CODE_25C + TEMP_CODE_TOL;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rate_word    <= '0;
            temp_word    <= '0;
            temp_in_band <= 1'b0;
            status_byte  <= 8'h00;
        end
        else
        begin
            rate_word <= self_active ? rate_raw + SELF_TEST_OFFSET : rate_raw;
            // Temperature leaves only through the serial word when digital
            temp_word    <= mode_digital ? temp_raw : '0;
            temp_in_band <= (temp_raw >= temp_lo) && (temp_raw <= temp_hi);
            status_byte  <= '0;
            status_byte[ST_FAIL_BIT]   <= health_fail || self_active;
            status_byte[ST_BADSUM_BIT] <= bad_sum;
            status_byte[ST_SELF_BIT]   <= self_active;
        end
    end

    // ****************************************
    // Interrupt registers
    // ****************************************
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_MASK   = 2'h1;
    localparam logic [1:0] ADDR_STATE  = 2'h2;

    logic [EV_N-1:0] irq_status;
    logic [EV_N-1:0] irq_mask;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] ev_level;
    logic [EV_N-1:0] ev_level_q;

    assign ev_level[EV_FAIL]   = !pass_out;
    assign ev_level[EV_BADSUM] = bad_sum;
    assign ev_level[EV_SELF]   = self_active;

    // Each event is the rising edge of its level; history resets high so reset gives no false edge
    for (genvar g = 0; g < EV_N; g++)
    begin : g_event
        assign ev[g] = ev_level[g] && !ev_level_q[g];
    end

    wire wr_status = reg_wr && reg_addr == ADDR_STATUS;
    wire wr_mask   = reg_wr && reg_addr == ADDR_MASK;
    wire [EV_N-1:0] clr = wr_status ? reg_wdata[EV_N-1:0] : '0;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_status <= '0;
            irq_mask   <= '0;
            ev_level_q <= '1;
            reg_rdata  <= 8'h00;
        end
        else
        begin
            ev_level_q <= ev_level;
            // A new event wins over a simultaneous clear
            irq_status <= (irq_status & ~clr) | ev;
            if (wr_mask)
                irq_mask <= reg_wdata[EV_N-1:0];
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    ADDR_STATUS: reg_rdata <= {5'h00, irq_status};
                    ADDR_MASK:   reg_rdata <= {5'h00, irq_mask};
                    ADDR_STATE:  reg_rdata <= status_byte;
                    default:     reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule
`default_nettype wire
